// ==== common/prc_defines.vh ====
`ifndef PRC_DEFINES_VH
`define PRC_DEFINES_VH

// ============================================================
// Widths
`define PRC_ADDR_W          8
`define PRC_DATA_W          32
`define PRC_POS_W           32
`define PRC_CMD_W           10

// ============================================================
// Register byte offsets
`define PRC_REG_ARM         8'h00
`define PRC_REG_STATUS      8'h04
`define PRC_REG_OPEN        8'h08
`define PRC_REG_CLOSE       8'h0C
`define PRC_REG_POS_PRI     8'h10
`define PRC_REG_POS_SEC     8'h14
`define PRC_REG_MEAS        8'h18
`define PRC_REG_CONFIG      8'h1C

// ============================================================
// Arm command layout: mode code low, window code above it
`define PRC_MODE_LSB        0
`define PRC_MODE_MSB        7
`define PRC_WIN_LSB         8
`define PRC_WIN_MSB         9

// Window codes (mode plus 256 or plus 768)
`define PRC_WIN_NONE        2'h0
`define PRC_WIN_INCL        2'h1
`define PRC_WIN_EXCL        2'h3

// ============================================================
// Mode codes
`define PRC_MODE_IDX_R      8'h01
`define PRC_MODE_IDX_F      8'h02
`define PRC_MODE_A_R        8'h03
`define PRC_MODE_A_F        8'h04
`define PRC_MODE_AR_IR      8'h06
`define PRC_MODE_AR_IF      8'h07
`define PRC_MODE_AF_IR      8'h08
`define PRC_MODE_AF_IF      8'h09
`define PRC_MODE_AR_BR      8'h0A
`define PRC_MODE_AR_BF      8'h0B
`define PRC_MODE_AF_BR      8'h0C
`define PRC_MODE_AF_BF      8'h0D

// ============================================================
// Trigger sources, also the bit index into the edge vectors
`define PRC_SRC_W           2
`define PRC_NUM_SRC         3
`define PRC_SRC_INDEX       2'h0
`define PRC_SRC_A           2'h1
`define PRC_SRC_B           2'h2

// ============================================================
// Status bit positions
`define PRC_ST_PRI_FLAG     0
`define PRC_ST_SEC_FLAG     1
`define PRC_ST_PRI_ARMED    2
`define PRC_ST_SEC_ARMED    3

// Config read-back bit positions
`define PRC_CF_PRI_SRC_LSB  0
`define PRC_CF_PRI_RISE     2
`define PRC_CF_SEC_SRC_LSB  4
`define PRC_CF_SEC_RISE     6
`define PRC_CF_WIN_LSB      8

// ============================================================
// Reset values
`define PRC_RST_POS         32'h00000000
`define PRC_RST_CMD         10'h000
`define PRC_RST_WORD        32'h00000000

`endif

// ==== verilog/prc_edge_detect.v ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Edge detector, one lane per trigger source
module prc_edge_detect #(
	parameter WIDTH = 3
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] sig,
	output wire [WIDTH-1:0] rise,
	output wire [WIDTH-1:0] fall
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
			reg prev;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					prev <= 1'b0;
				end else begin
					prev <= sig[i];
				end
			end
			// Edge is seen in the cycle the new level arrives
			assign rise[i] = sig[i] & ~prev;
			assign fall[i] = ~sig[i] & prev;
		end
	endgenerate

endmodule // prc_edge_detect

`default_nettype wire

// ==== verilog/prc_window_check.v ====
`timescale 1ns/1ps
`include "prc_defines.vh"
`default_nettype none

// ============================================================
// Window acceptance on signed positions
module prc_window_check #(
	parameter POS_W = 32
) (
	input  wire [POS_W-1:0] position,
	input  wire [POS_W-1:0] open_limit,
	input  wire [POS_W-1:0] close_limit,
	input  wire [1:0]       win_mode,
	output reg              accept
);

	wire above_open  = $signed(position) > $signed(open_limit);
	wire below_close = $signed(position) < $signed(close_limit);
	wire below_open  = $signed(position) < $signed(open_limit);
	wire above_close = $signed(position) > $signed(close_limit);

	always @* begin
		case (win_mode)
		`PRC_WIN_INCL: begin
			accept = above_open & below_close;
		end
		`PRC_WIN_EXCL: begin
			accept = below_open | above_close;
		end
		default: begin
			accept = 1'b1;
		end
		endcase
	end

endmodule // prc_window_check

`default_nettype wire

// ==== verilog/prc_capture_top.v ====
// Contract
// - Second axis keeps two independent capture registers, primary and secondary.
// - Trigger source selectable among input A, input B and encoder index.
// - Accepted primary trigger sets primary flag and loads primary position.
// - Accepted secondary trigger sets secondary flag and loads secondary position.
// - Inclusive window: accept only strictly between open and close limits.
// - Exclusive window: accept only strictly below open or above close.
// - Each capture needs its own arm; no recapture until re-armed.
// - Mode 1 index rising, mode 2 index falling, into primary register.
// - Mode 3 input A rising, mode 4 input A falling, into primary.
// - Modes 6 to 9: A primary, index secondary, four edge pairs.
// - Modes 10 to 13: A primary, B secondary, four edge pairs.
// - Position latched by hardware in the trigger edge cycle.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "prc_defines.vh"
`default_nettype none

module prc_capture_top (
	input  wire                   pclk,
	input  wire                   presetn,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [`PRC_ADDR_W-1:0] paddr,
	input  wire [`PRC_DATA_W-1:0] pwdata,
	output reg  [`PRC_DATA_W-1:0] prdata,
	output reg                    pready,
	output reg                    pslverr,
	input  wire                   registration_input_a,
	input  wire                   registration_input_b,
	input  wire                   encoder_index,
	input  wire [`PRC_POS_W-1:0]  measured_axis_position,
	output reg                    primary_capture_flag,
	output reg                    secondary_capture_flag,
	output reg                    primary_armed,
	output reg                    secondary_armed
);

	// ============================================================
	// APB phases
	wire setup_phase  = psel & ~penable;
	wire access_phase = psel & penable & pready;
	wire bus_write    = access_phase & pwrite;

	reg addr_mapped;
	always @* begin
		case (paddr)
		`PRC_REG_ARM,
		`PRC_REG_STATUS,
		`PRC_REG_OPEN,
		`PRC_REG_CLOSE,
		`PRC_REG_POS_PRI,
		`PRC_REG_POS_SEC,
		`PRC_REG_MEAS,
		`PRC_REG_CONFIG: begin
			addr_mapped = 1'b1;
		end
		default: begin
			addr_mapped = 1'b0;
		end
		endcase
	end

	wire arm_write   = bus_write & (paddr == `PRC_REG_ARM);
	wire open_write  = bus_write & (paddr == `PRC_REG_OPEN);
	wire close_write = bus_write & (paddr == `PRC_REG_CLOSE);

	// ============================================================
	// Software-held command and window limits, hardware-latched capture positions
	reg [`PRC_CMD_W-1:0] arm_command;
	reg [`PRC_POS_W-1:0] window_open_limit;
	reg [`PRC_POS_W-1:0] window_close_limit;
	reg [`PRC_POS_W-1:0] primary_capture_position;
	reg [`PRC_POS_W-1:0] secondary_capture_position;

	// Live arming configuration
	reg [`PRC_SRC_W-1:0] pri_src;
	reg                  pri_rise;
	reg [`PRC_SRC_W-1:0] sec_src;
	reg                  sec_rise;
	reg [1:0]            win_mode;

	// ============================================================
	// Arm command decode
	wire [`PRC_CMD_W-1:0] cmd_word = pwdata[`PRC_CMD_W-1:0];
	wire [7:0] cmd_mode = cmd_word[`PRC_MODE_MSB:`PRC_MODE_LSB];
	wire [1:0] cmd_win  = cmd_word[`PRC_WIN_MSB:`PRC_WIN_LSB];

	reg                  next_valid;
	reg                  next_pri_arm;
	reg                  next_sec_arm;
	reg [`PRC_SRC_W-1:0] next_pri_src;
	reg                  next_pri_rise;
	reg [`PRC_SRC_W-1:0] next_sec_src;
	reg                  next_sec_rise;

	always @* begin
		next_valid    = 1'b1;
		next_pri_arm  = 1'b1;
		next_sec_arm  = 1'b1;
		next_pri_src  = `PRC_SRC_A;
		next_pri_rise = 1'b1;
		next_sec_src  = `PRC_SRC_INDEX;
		next_sec_rise = 1'b1;
		case (cmd_mode)
		`PRC_MODE_IDX_R: begin
			next_pri_src = `PRC_SRC_INDEX;
			next_sec_arm = 1'b0;
		end
		`PRC_MODE_IDX_F: begin
			next_pri_src  = `PRC_SRC_INDEX;
			next_pri_rise = 1'b0;
			next_sec_arm  = 1'b0;
		end
		`PRC_MODE_A_R: begin
			next_sec_arm = 1'b0;
		end
		`PRC_MODE_A_F: begin
			next_pri_rise = 1'b0;
			next_sec_arm  = 1'b0;
		end
		`PRC_MODE_AR_IR: begin
		end
		`PRC_MODE_AR_IF: begin
			next_sec_rise = 1'b0;
		end
		`PRC_MODE_AF_IR: begin
			next_pri_rise = 1'b0;
		end
		`PRC_MODE_AF_IF: begin
			next_pri_rise = 1'b0;
			next_sec_rise = 1'b0;
		end
		`PRC_MODE_AR_BR: begin
			next_sec_src = `PRC_SRC_B;
		end
		`PRC_MODE_AR_BF: begin
			next_sec_src  = `PRC_SRC_B;
			next_sec_rise = 1'b0;
		end
		`PRC_MODE_AF_BR: begin
			next_sec_src  = `PRC_SRC_B;
			next_pri_rise = 1'b0;
		end
		`PRC_MODE_AF_BF: begin
			next_sec_src  = `PRC_SRC_B;
			next_pri_rise = 1'b0;
			next_sec_rise = 1'b0;
		end
		default: begin
			// Mode 5 and unknown codes are dropped whole
			next_valid   = 1'b0;
			next_pri_arm = 1'b0;
			next_sec_arm = 1'b0;
		end
		endcase
	end

	wire arm_accept = arm_write & next_valid;

	// ============================================================
	// Trigger path
	wire [`PRC_NUM_SRC-1:0] src_level;
	wire [`PRC_NUM_SRC-1:0] src_rise;
	wire [`PRC_NUM_SRC-1:0] src_fall;
	wire                    window_ok;

	assign src_level[`PRC_SRC_INDEX] = encoder_index;
	assign src_level[`PRC_SRC_A]     = registration_input_a;
	assign src_level[`PRC_SRC_B]     = registration_input_b;

	prc_edge_detect #(
		.WIDTH (`PRC_NUM_SRC)
	) u_edges (
		.clk   (pclk),
		.rst_n (presetn),
		.sig   (src_level),
		.rise  (src_rise),
		.fall  (src_fall)
	);

	prc_window_check #(
		.POS_W (`PRC_POS_W)
	) u_window (
		.position    (measured_axis_position),
		.open_limit  (window_open_limit),
		.close_limit (window_close_limit),
		.win_mode    (win_mode),
		.accept      (window_ok)
	);

	wire pri_edge = pri_rise ? src_rise[pri_src] : src_fall[pri_src];
	wire sec_edge = sec_rise ? src_rise[sec_src] : src_fall[sec_src];

	// Window is judged against the position of the edge cycle itself
	wire pri_hit = primary_armed & pri_edge & window_ok;
	wire sec_hit = secondary_armed & sec_edge & window_ok;

	// ============================================================
	// Arming, flags and capture registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_command            <= `PRC_RST_CMD;
			pri_src                <= `PRC_SRC_A;
			pri_rise               <= 1'b1;
			sec_src                <= `PRC_SRC_INDEX;
			sec_rise               <= 1'b1;
			win_mode               <= `PRC_WIN_NONE;
			primary_armed          <= 1'b0;
			secondary_armed        <= 1'b0;
			primary_capture_flag   <= 1'b0;
			secondary_capture_flag <= 1'b0;
		end else begin
			if (arm_accept) begin
				arm_command <= cmd_word;
				pri_src     <= next_pri_src;
				pri_rise    <= next_pri_rise;
				sec_src     <= next_sec_src;
				sec_rise    <= next_sec_rise;
				// Code 2 in the window field means no window
				win_mode    <= (cmd_win == `PRC_WIN_INCL ||
				                cmd_win == `PRC_WIN_EXCL) ?
				               cmd_win : `PRC_WIN_NONE;
			end
			// A capture disarms its channel until the next arm
			if (arm_accept) begin
				primary_armed   <= next_pri_arm;
				secondary_armed <= next_sec_arm;
			end else begin
				if (pri_hit) begin
					primary_armed <= 1'b0;
				end
				if (sec_hit) begin
					secondary_armed <= 1'b0;
				end
			end
			// Set wins over the clear of a simultaneous arm
			if (pri_hit) begin
				primary_capture_flag <= 1'b1;
			end else if (arm_accept) begin
				primary_capture_flag <= 1'b0;
			end
			if (sec_hit) begin
				secondary_capture_flag <= 1'b1;
			end else if (arm_accept) begin
				secondary_capture_flag <= 1'b0;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_capture_position   <= `PRC_RST_POS;
			secondary_capture_position <= `PRC_RST_POS;
			window_open_limit          <= `PRC_RST_POS;
			window_close_limit         <= `PRC_RST_POS;
		end else begin
			// Latched in the edge cycle, no software in the path
			if (pri_hit) begin
				primary_capture_position <= measured_axis_position;
			end
			if (sec_hit) begin
				secondary_capture_position <= measured_axis_position;
			end
			if (open_write) begin
				window_open_limit <= pwdata;
			end
			if (close_write) begin
				window_close_limit <= pwdata;
			end
		end
	end

	// ============================================================
	// Read mux and APB answer
	reg [`PRC_DATA_W-1:0] next_rdata;
	always @* begin
		next_rdata = `PRC_RST_WORD;
		case (paddr)
		`PRC_REG_ARM: begin
			next_rdata[`PRC_CMD_W-1:0] = arm_command;
		end
		`PRC_REG_STATUS: begin
			next_rdata[`PRC_ST_PRI_FLAG]  = primary_capture_flag;
			next_rdata[`PRC_ST_SEC_FLAG]  = secondary_capture_flag;
			next_rdata[`PRC_ST_PRI_ARMED] = primary_armed;
			next_rdata[`PRC_ST_SEC_ARMED] = secondary_armed;
		end
		`PRC_REG_OPEN: begin
			next_rdata = window_open_limit;
		end
		`PRC_REG_CLOSE: begin
			next_rdata = window_close_limit;
		end
		`PRC_REG_POS_PRI: begin
			next_rdata = primary_capture_position;
		end
		`PRC_REG_POS_SEC: begin
			next_rdata = secondary_capture_position;
		end
		`PRC_REG_MEAS: begin
			next_rdata = measured_axis_position;
		end
		`PRC_REG_CONFIG: begin
			next_rdata[`PRC_CF_PRI_SRC_LSB+1:`PRC_CF_PRI_SRC_LSB] = pri_src;
			next_rdata[`PRC_CF_PRI_RISE]                        = pri_rise;
			next_rdata[`PRC_CF_SEC_SRC_LSB+1:`PRC_CF_SEC_SRC_LSB] = sec_src;
			next_rdata[`PRC_CF_SEC_RISE]                        = sec_rise;
			next_rdata[`PRC_CF_WIN_LSB+1:`PRC_CF_WIN_LSB]       = win_mode;
		end
		default: begin
			next_rdata = `PRC_RST_WORD;
		end
		endcase
	end

	// No wait state: read data is sampled in setup so it is a flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `PRC_RST_WORD;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase & ~addr_mapped;
			if (setup_phase) begin
				prdata <= pwrite ? `PRC_RST_WORD : next_rdata;
			end
		end
	end

endmodule // prc_capture_top

`default_nettype wire

// ==== verification/prc_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Index and registration sensors with a position source
// Only the second axis is fed; the first latches inside its drive
module prc_sensor_model (
	input  wire logic        pclk,
	output var  logic [2:0]  level,
	output var  logic [31:0] position
);
	initial begin
		level = 3'h0;
		position = 32'h00000000;
	end
	// Levels move just after an edge, as a synchronised sensor does
	task automatic put(input logic [1:0] src, input logic v,
		input logic [31:0] p);
		@(posedge pclk);
		level[src] <= v;
		position <= p;
	endtask
endmodule // prc_sensor_model
`default_nettype wire

// ==== verification/prc_capture_top_properties.sv ====
`timescale 1ns/1ps
`include "prc_defines.vh"
`default_nettype none
// ============================================================
// Port-level checker for the capture block
module prc_capture_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        registration_input_a,
	input wire logic        registration_input_b,
	input wire logic        encoder_index,
	input wire logic [31:0] measured_axis_position,
	input wire logic        primary_capture_flag,
	input wire logic        secondary_capture_flag,
	input wire logic        primary_armed,
	input wire logic        secondary_armed
);
	logic [2:0] lv_q;
	wire  [2:0] lv = {registration_input_b, registration_input_a,
		encoder_index};
	wire arm_wr = psel && penable && pready && pwrite &&
		paddr == `PRC_REG_ARM;
	wire bad_mode = pwdata[7:0] == 8'h00 || pwdata[7:0] == 8'h05 ||
		pwdata[7:0] > 8'h0D;
	// Cleared like the edge detector, so release gives no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lv_q <= 3'h0;
		end else begin
			lv_q <= lv;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_one_access;
		pready ##1 !pready;
	endsequence
	sequence s_idle_bad_arm;
		arm_wr && bad_mode && !primary_armed && !secondary_armed;
	endsequence
	a_pready_single: assert property (s_setup |=> s_one_access)
		else $error("pready not one cycle after setup");
	a_err_unmapped: assert property (pready && paddr[1:0] == 2'h0 |->
		pslverr == (paddr > 8'h1C)) else $error("wrong pslverr");
	a_pri_needs_arm: assert property (
		$rose(primary_capture_flag) |-> $past(primary_armed))
		else $error("primary capture while unarmed");
	a_sec_needs_arm: assert property (
		$rose(secondary_capture_flag) |-> $past(secondary_armed))
		else $error("secondary capture while unarmed");
	a_pri_disarms: assert property (
		$rose(primary_capture_flag) && !$past(arm_wr) |-> !primary_armed)
		else $error("still armed after capture");
	a_pri_on_edge: assert property (
		$rose(primary_capture_flag) |-> $past(lv[1:0] != lv_q[1:0]))
		else $error("primary flag without input edge");
	a_sec_on_edge: assert property (
		$rose(secondary_capture_flag) |->
		$past(lv[0] != lv_q[0] || lv[2] != lv_q[2]))
		else $error("secondary flag without input edge");
	a_flag_clear_cause: assert property (
		$fell(primary_capture_flag) || $fell(secondary_capture_flag)
		|-> $past(arm_wr)) else $error("flag cleared without arm");
	a_bad_mode_inert: assert property (s_idle_bad_arm |=>
		!primary_armed && !secondary_armed &&
		$stable({primary_capture_flag, secondary_capture_flag}))
		else $error("invalid mode changed state");
endmodule // prc_capture_props
bind prc_capture_top prc_capture_props u_props (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.registration_input_a, .registration_input_b, .encoder_index,
	.measured_axis_position, .primary_capture_flag,
	.secondary_capture_flag, .primary_armed, .secondary_armed);
`default_nettype wire

// ==== verification/prc_capture_top_tb.sv ====
`timescale 1ns/1ps
`include "prc_defines.vh"
`default_nettype none
module prc_capture_top_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         primary_capture_flag;
	wire         secondary_capture_flag;
	wire         primary_armed;
	wire         secondary_armed;
	wire  [2:0]  lv;
	wire  [31:0] pos;
	int          n_errors = 0;
	int          n_compared = 0;
	logic [31:0] rd;
	logic        er;
	always #4 pclk = ~pclk;
	prc_capture_top dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.registration_input_a(lv[1]), .registration_input_b(lv[2]),
		.encoder_index(lv[0]), .measured_axis_position(pos),
		.primary_capture_flag, .secondary_capture_flag, .primary_armed,
		.secondary_armed);
	prc_sensor_model sm (.pclk(pclk), .level(lv), .position(pos));
	// ============================================================
	// Common tasks
	task close_out;
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Request holds until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) n_errors++;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// ============================================================
	// Scenarios
	task t_regs;
		for (int i = 0; i < 7; i++) rdchk(8'(i * 4), 32'h0);
		// Reset arming: primary on input A rising, secondary index rising
		rdchk(`PRC_REG_CONFIG, 32'h45);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, `PRC_REG_STATUS, 32'hF);
		rdchk(`PRC_REG_STATUS, 32'h0);
		apb(1'b1, `PRC_REG_OPEN, 32'hA);
		rdchk(`PRC_REG_OPEN, 32'hA);
		apb(1'b1, `PRC_REG_CLOSE, 32'h14);
		rdchk(`PRC_REG_CLOSE, 32'h14);
	endtask
	task t_single;
		logic [1:0] s;
		logic r;
		for (int m = 1; m <= 4; m++) begin
			s = (m < 3) ? `PRC_SRC_INDEX : `PRC_SRC_A;
			r = m[0];
			sm.put(s, r, 32'h0);
			apb(1'b1, `PRC_REG_ARM, m);
			rdchk(`PRC_REG_STATUS, 32'h4);
			sm.put(s, !r, 32'h5);
			rdchk(`PRC_REG_STATUS, 32'h4);
			sm.put(s, r, 32'h100 + m);
			rdchk(`PRC_REG_STATUS, 32'h1);
			rdchk(`PRC_REG_POS_PRI, 32'h100 + m);
			sm.put(s, !r, 32'h7);
			sm.put(s, r, 32'h7);
			rdchk(`PRC_REG_POS_PRI, 32'h100 + m);
		end
	endtask
	task t_dual;
		logic [1:0] s;
		logic [1:0] k;
		for (int m = 6; m <= 13; m++) begin
			s = (m < 10) ? `PRC_SRC_INDEX : `PRC_SRC_B;
			k = 2'((m < 10) ? m - 6 : m - 10);
			sm.put(`PRC_SRC_A, k[1], 32'h0);
			sm.put(s, k[0], 32'h0);
			apb(1'b1, `PRC_REG_ARM, m);
			rdchk(`PRC_REG_STATUS, 32'hC);
			sm.put(`PRC_SRC_A, !k[1], 32'h200 + m);
			sm.put(s, !k[0], 32'h300 + m);
			rdchk(`PRC_REG_STATUS, 32'h3);
			chk({28'h0, secondary_armed, primary_armed, secondary_capture_flag,
				primary_capture_flag}, 32'h3);
			rdchk(`PRC_REG_POS_PRI, 32'h200 + m);
			rdchk(`PRC_REG_POS_SEC, 32'h300 + m);
		end
	endtask
	task a_edge(input logic [31:0] p);
		sm.put(`PRC_SRC_A, 1'b0, p);
		sm.put(`PRC_SRC_A, 1'b1, p);
	endtask
	task t_window;
		apb(1'b1, `PRC_REG_ARM, 32'h103);
		a_edge(32'hA);
		rdchk(`PRC_REG_STATUS, 32'h4);
		a_edge(32'hB);
		rdchk(`PRC_REG_POS_PRI, 32'hB);
		apb(1'b1, `PRC_REG_ARM, 32'h303);
		rdchk(`PRC_REG_ARM, 32'h303);
		a_edge(32'h14);
		rdchk(`PRC_REG_STATUS, 32'h4);
		a_edge(32'hFFFFFFFD);
		rdchk(`PRC_REG_POS_PRI, 32'hFFFFFFFD);
	endtask
	task t_invalid;
		apb(1'b1, `PRC_REG_ARM, 32'h5);
		rdchk(`PRC_REG_STATUS, 32'h1);
		apb(1'b1, `PRC_REG_ARM, 32'hE);
		a_edge(32'h33);
		rdchk(`PRC_REG_POS_PRI, 32'hFFFFFFFD);
		apb(1'b1, `PRC_REG_ARM, 32'h3);
		rdchk(`PRC_REG_STATUS, 32'h4);
		apb(1'b1, `PRC_REG_ARM, 32'h0);
		rdchk(`PRC_REG_ARM, 32'h3);
		rdchk(`PRC_REG_STATUS, 32'h4);
		a_edge(32'h44);
		rdchk(`PRC_REG_POS_PRI, 32'h44);
		rdchk(`PRC_REG_MEAS, 32'h44);
	endtask
	// ============================================================
	// Main sequence and watchdog
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_single;
		t_dual;
		t_window;
		t_invalid;
		close_out;
	end
	// Whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		close_out;
	end
endmodule // prc_capture_top_tb
`default_nettype wire
